// file: hw/tltb_pkg.sv
// tltb_pkg: types and match helpers of the two-level translation buffer
// assumes: tltb_regs.svh sits on the include path
`include "tltb_regs.svh"
package tltb_pkg;
   typedef struct packed {
      logic valid;
      logic [1:0] size;
      logic [`TLTB_VPN_W-1:0] vpn;
      logic [`TLTB_PPN_W-1:0] ppn;
   } tltb_entry_t;
   typedef enum logic [1:0] {ST_IDLE, ST_L2, ST_WALK} tltb_fsm_t;
   typedef struct packed {
      logic data;
      logic fault;
      logic [`TLTB_PA_W-1:0] paddr;
   } tltb_resp_t;
   typedef struct packed {
      logic fault;
      logic [1:0] size;
      logic [`TLTB_PPN_W-1:0] ppn;
   } tltb_walk_t;
   typedef struct packed {
      tltb_fsm_t st;
      logic is_d;
      logic [`TLTB_VA_W-1:0] va;
      logic resp_v;
      tltb_resp_t resp;
      logic [5:0] i_ptr;
      logic [4:0] l_ptr;
      logic [5:0] d_ptr;
      logic [1:0] i2_way;
      logic [2:0] d2_way;
      tltb_entry_t [`TLTB_L1I_SMALL-1:0] l1i_s;
      tltb_entry_t [`TLTB_L1I_LARGE-1:0] l1i_l;
      tltb_entry_t [`TLTB_L1D_MAX-1:0] l1d;
      tltb_entry_t [`TLTB_L2_SETS-1:0][`TLTB_L2I_WAYS-1:0] l2i;
      tltb_entry_t [`TLTB_L2_SETS-1:0][`TLTB_L2D_WAYS-1:0] l2d;
   } tltb_state_t;

   // vpn bits that take part in the compare for a page size
   function automatic logic [`TLTB_VPN_W-1:0] size_mask(logic [1:0] sz);
      unique case (sz)
         `TLTB_SZ_4K: return {`TLTB_VPN_W{1'b1}};
         `TLTB_SZ_1G: return {{(`TLTB_VPN_W-18){1'b1}}, 18'h0};
         default: return {{(`TLTB_VPN_W-9){1'b1}}, 9'h0};
      endcase
   endfunction : size_mask

   function automatic logic hit(tltb_entry_t e, logic [`TLTB_VPN_W-1:0] v);
      return e.valid && (((e.vpn ^ v) & size_mask(e.size)) == '0);
   endfunction : hit

   // page frame with the in-page vpn bits carried over
   function automatic logic [`TLTB_PPN_W-1:0] xlate(tltb_entry_t e,
         logic [`TLTB_VPN_W-1:0] v);
      logic [`TLTB_VPN_W-1:0] full;
      logic [`TLTB_PPN_W-1:0] m;
      // a call result cannot be sliced directly, so it goes through a temporary
      full = size_mask(e.size);
      m = full[`TLTB_PPN_W-1:0];
      return (e.ppn & m) | (v[`TLTB_PPN_W-1:0] & ~m);
   endfunction : xlate
endpackage : tltb_pkg

// file: hw/tltb_regs.svh
// tltb_regs.svh: sizes, field codes and widths of the translation buffer pair
// assumes: included by the package and the top module by bare name
`ifndef TLTB_REGS_SVH
`define TLTB_REGS_SVH
`define TLTB_VA_W 48
`define TLTB_PA_W 40
`define TLTB_VPN_W 36
`define TLTB_PPN_W 28
`define TLTB_L1I_SMALL 48
`define TLTB_L1I_LARGE 24
`define TLTB_L1D_MAX 64
`define TLTB_L1D_DEF 64
`define TLTB_L2I_WAYS 4
`define TLTB_L2D_WAYS 8
`define TLTB_L2_SETS 128
`define TLTB_SZ_4K 2'h0
`define TLTB_SZ_2M 2'h1
`define TLTB_SZ_1G 2'h2
`define TLTB_SZ_4M 2'h3
`endif

// file: hw/tltb_top.sv
// tltb_top: first and second level translation buffers for fetch and load-store
// assumes: requesters and the page walker run on mclk_in; one miss in flight
//
// Function
// - the first-level instruction buffer is fully associative with 48 entries for 4-Kbyte pages.
// - it also has 24 entries each holding one 2-Mbyte or 1-Gbyte page.
// - a 4-Mbyte page is stored as two 2-Mbyte entries in every buffer holding large pages.
// - the first-level data buffer is fully associative and holds 4K, 2M and 1G pages.
// - the first-level data buffer depth is a build parameter, 32 or 64 entries.
// - the second-level instruction buffer is 4-way with 512 entries of 4-Kbyte pages only.
// - the second-level data buffer holds walked translations only, 1024 entries, 8-way, all sizes.
`timescale 1ns/1ps
`include "tltb_regs.svh"
module tltb_top #(
   parameter int L1D_DEPTH = `TLTB_L1D_DEF
) (
   // clock, reset, enable
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // fetch requests
   input wire logic ireq_valid_in,
   input wire logic [`TLTB_VA_W-1:0] ireq_vaddr_in,
   output logic ireq_ready_out,
   // load-store requests
   input wire logic dreq_valid_in,
   input wire logic [`TLTB_VA_W-1:0] dreq_vaddr_in,
   output logic dreq_ready_out,
   // answers
   output logic resp_valid_out,
   output tltb_pkg::tltb_resp_t resp_out,
   // page walker
   output logic walk_req_out,
   output logic walk_is_data_out,
   output logic [`TLTB_VA_W-1:0] walk_vaddr_out,
   input wire logic walk_resp_valid_in,
   input wire tltb_pkg::tltb_walk_t walk_resp_in
);
   // ****************************************
   // reset release
   // ****************************************
   logic [1:0] rst_sync_r;
   logic rst_n;
   // release is synchronised, assertion stays asynchronous
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ****************************************
   // lookup
   // ****************************************
   tltb_pkg::tltb_state_t r;
   tltb_pkg::tltb_state_t nxt;
   logic [`TLTB_VA_W-1:0] sel_va;
   logic [`TLTB_VPN_W-1:0] sel_vpn;
   logic [`TLTB_VPN_W-1:0] miss_vpn;
   logic [6:0] set_i;
   logic [6:0] set_d;
   logic [`TLTB_L1I_SMALL-1:0] hit_s;
   logic [`TLTB_L1I_LARGE-1:0] hit_l;
   logic [`TLTB_L1D_MAX-1:0] hit_d;
   logic accept;

   assign ireq_ready_out = (r.st == tltb_pkg::ST_IDLE);
   assign dreq_ready_out = (r.st == tltb_pkg::ST_IDLE) && !ireq_valid_in; // fetch first
   assign accept = ireq_valid_in || dreq_valid_in;
   assign sel_va = ireq_valid_in ? ireq_vaddr_in : dreq_vaddr_in;
   assign sel_vpn = sel_va[`TLTB_VA_W-1:12];
   assign miss_vpn = r.va[`TLTB_VA_W-1:12];
   assign set_i = miss_vpn[6:0];
   // bits shared by every page size, so one probe finds any size
   assign set_d = miss_vpn[24:18];
   assign resp_valid_out = r.resp_v;
   assign resp_out = r.resp;
   assign walk_req_out = (r.st == tltb_pkg::ST_WALK);
   assign walk_is_data_out = r.is_d;
   assign walk_vaddr_out = r.va;

   // fully associative compare of every first-level entry
   for (genvar g = 0; g < `TLTB_L1I_SMALL; g++) begin : g_ls
      assign hit_s[g] = tltb_pkg::hit(r.l1i_s[g], sel_vpn);
   end
   for (genvar g = 0; g < `TLTB_L1I_LARGE; g++) begin : g_ll
      assign hit_l[g] = tltb_pkg::hit(r.l1i_l[g], sel_vpn);
   end
   for (genvar g = 0; g < `TLTB_L1D_MAX; g++) begin : g_d
      assign hit_d[g] = (g < L1D_DEPTH) && tltb_pkg::hit(r.l1d[g], sel_vpn);
   end

   // ****************************************
   // fill helpers
   // ****************************************
   // round-robin victim in the first level of one side
   function automatic tltb_pkg::tltb_state_t fill_l1(tltb_pkg::tltb_state_t s,
         tltb_pkg::tltb_entry_t e);
      if (s.is_d) begin
         s.l1d[s.d_ptr] = e;
         s.d_ptr = (s.d_ptr == 6'(L1D_DEPTH - 1)) ? 6'h0 : s.d_ptr + 6'h1;
      end else if (e.size == `TLTB_SZ_4K) begin
         s.l1i_s[s.i_ptr] = e;
         s.i_ptr = (s.i_ptr == 6'(`TLTB_L1I_SMALL - 1)) ? 6'h0 : s.i_ptr + 6'h1;
      end else begin
         s.l1i_l[s.l_ptr] = e;
         s.l_ptr = (s.l_ptr == 5'(`TLTB_L1I_LARGE - 1)) ? 5'h0 : s.l_ptr + 5'h1;
      end
      return s;
   endfunction : fill_l1

   // second level: large instruction pages stay out, the 4K-only array
   function automatic tltb_pkg::tltb_state_t fill_l2(tltb_pkg::tltb_state_t s,
         tltb_pkg::tltb_entry_t e, logic [6:0] si, logic [6:0] sd);
      if (s.is_d) begin
         s.l2d[sd][s.d2_way] = e;
         s.d2_way = s.d2_way + 3'h1;
      end else if (e.size == `TLTB_SZ_4K) begin
         s.l2i[si][s.i2_way] = e;
         s.i2_way = s.i2_way + 2'h1;
      end
      return s;
   endfunction : fill_l2

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      tltb_pkg::tltb_entry_t e;
      tltb_pkg::tltb_entry_t h0;
      tltb_pkg::tltb_entry_t h1;
      logic found;
      e = '0;
      h0 = '0;
      h1 = '0;
      found = 1'b0;
      nxt = r;
      nxt.resp_v = 1'b0;
      unique case (r.st)
         tltb_pkg::ST_IDLE: begin
            if (accept) begin
               for (int i = 0; i < `TLTB_L1I_SMALL; i++) begin
                  if (ireq_valid_in && hit_s[i]) begin
                     e = r.l1i_s[i];
                  end
               end
               for (int i = 0; i < `TLTB_L1I_LARGE; i++) begin
                  if (ireq_valid_in && hit_l[i]) begin
                     e = r.l1i_l[i];
                  end
               end
               for (int i = 0; i < `TLTB_L1D_MAX; i++) begin
                  if (!ireq_valid_in && hit_d[i]) begin
                     e = r.l1d[i];
                  end
               end
               nxt.is_d = !ireq_valid_in;
               nxt.va = sel_va;
               nxt.resp.data = !ireq_valid_in;
               nxt.resp.fault = 1'b0;
               if (e.valid) begin
                  nxt.resp_v = 1'b1;
                  nxt.resp.paddr = {tltb_pkg::xlate(e, sel_vpn), sel_va[11:0]};
               end else begin
                  nxt.st = tltb_pkg::ST_L2;
               end
            end
         end
         tltb_pkg::ST_L2: begin
            // second level probe of the missing side
            if (r.is_d) begin
               for (int w = 0; w < `TLTB_L2D_WAYS; w++) begin
                  if (tltb_pkg::hit(r.l2d[set_d][w], miss_vpn)) begin
                     e = r.l2d[set_d][w];
                  end
               end
            end else begin
               for (int w = 0; w < `TLTB_L2I_WAYS; w++) begin
                  if (tltb_pkg::hit(r.l2i[set_i][w], miss_vpn)) begin
                     e = r.l2i[set_i][w];
                  end
               end
            end
            if (e.valid) begin
               nxt = fill_l1(nxt, e);
               nxt.resp_v = 1'b1;
               nxt.resp.paddr = {tltb_pkg::xlate(e, miss_vpn), r.va[11:0]};
               nxt.st = tltb_pkg::ST_IDLE;
            end else begin
               nxt.st = tltb_pkg::ST_WALK;
            end
         end
         tltb_pkg::ST_WALK: begin
            if (walk_resp_valid_in) begin
               found = !walk_resp_in.fault;
               e = '{valid: found, size: walk_resp_in.size, vpn: miss_vpn,
                     ppn: walk_resp_in.ppn};
               // a 4M page lands as its two 2M halves
               h0 = e;
               h0.size = `TLTB_SZ_2M;
               h0.vpn[9] = 1'b0;
               h0.ppn[9] = 1'b0;
               h1 = h0;
               h1.vpn[9] = 1'b1;
               h1.ppn[9] = 1'b1;
               if (found && walk_resp_in.size == `TLTB_SZ_4M) begin
                  nxt = fill_l1(nxt, h0);
                  nxt = fill_l1(nxt, h1);
                  nxt = fill_l2(nxt, h0, set_i, set_d);
                  nxt = fill_l2(nxt, h1, set_i, set_d);
                  e = miss_vpn[9] ? h1 : h0;
               end else if (found) begin
                  nxt = fill_l1(nxt, e);
                  nxt = fill_l2(nxt, e, set_i, set_d);
               end
               nxt.resp_v = 1'b1;
               nxt.resp.fault = !found;
               nxt.resp.paddr = found ? {tltb_pkg::xlate(e, miss_vpn), r.va[11:0]} : '0;
               nxt.st = tltb_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt.st = tltb_pkg::ST_IDLE; // unused code
         end
      endcase
   end

   // single state register; enable low freezes everything
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else if (ce_in) begin
         r <= nxt;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n);
   sequence walk_4m_s;
      ce_in && walk_req_out && walk_resp_valid_in && !walk_resp_in.fault
         && walk_resp_in.size == `TLTB_SZ_4M;
   endsequence
   l1i_hit_answer_a: assert property (ce_in && r.st == tltb_pkg::ST_IDLE && ireq_valid_in
      && (|hit_s || |hit_l) |=> resp_valid_out && !resp_out.data)
      else $error("fetch first-level hit not answered next cycle");
   l1i_large_slot_a: assert property (walk_4m_s and (!r.is_d)
      |=> r.l_ptr != $past(r.l_ptr) && r.l1i_l[$past(r.l_ptr)].size == `TLTB_SZ_2M)
      else $error("large fetch page not placed in large slot");
   pair_halves_a: assert property (walk_4m_s and r.is_d
      |=> r.d_ptr == 6'((32'($past(r.d_ptr)) + 2) % L1D_DEPTH))
      else $error("4M page did not take two entries");
   l1d_hit_answer_a: assert property (ce_in && r.st == tltb_pkg::ST_IDLE && !ireq_valid_in
      && dreq_valid_in && |hit_d |=> resp_valid_out && resp_out.data)
      else $error("data first-level hit not answered next cycle");
   l1d_depth_a: assert property (32'(r.d_ptr) < L1D_DEPTH)
      else $error("data victim pointer beyond depth");
   l2i_small_only_a: assert property (ce_in && walk_req_out && walk_resp_valid_in
      && !r.is_d && walk_resp_in.size != `TLTB_SZ_4K |=> $stable(r.i2_way))
      else $error("large page written to 4K-only array");
   l2d_fill_a: assert property (ce_in && walk_req_out && walk_resp_valid_in && r.is_d
      && !walk_resp_in.fault |=> r.d2_way != $past(r.d2_way))
      else $error("data walk did not fill second level");
   miss_walk_a: assert property (ce_in && r.st == tltb_pkg::ST_L2 && !nxt.resp_v
      |=> walk_req_out ##0 !resp_valid_out)
      else $error("second-level miss did not start a walk");
   walk_done_a: assert property (ce_in && walk_req_out && walk_resp_valid_in
      |=> resp_valid_out && !walk_req_out)
      else $error("walk result not answered");
endmodule : tltb_top

// file: test/tltb_walker.sv
// tltb_walker.sv: behavioural page walker facing the translation buffer pair
// assumes: one walk at a time; the answer comes lag_in cycles after the request is seen
`timescale 1ns/1ps
`include "tltb_regs.svh"
module tltb_walker (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // walk request from the buffers
   input wire logic req_in,
   input wire logic [`TLTB_VA_W-1:0] vaddr_in,
   // knobs from the bench
   input wire logic [1:0] size_in,
   input wire logic fault_in,
   input wire logic [3:0] lag_in,
   // answer
   output logic valid_out,
   output tltb_pkg::tltb_walk_t resp_out,
   output int walks_out
);
   logic [3:0] cnt_r;
   logic sent_r;
   logic [`TLTB_PPN_W-1:0] frame;
   // ***************************************
   // frame base aligned to the page size
   // ***************************************
   always_comb begin
      frame = {4'h9, vaddr_in[35:12]};
      case (size_in)
         2'h1: frame[8:0] = 9'h0;
         2'h2: frame[17:0] = 18'h0;
         2'h3: frame[9:0] = 10'h0;
         default: ;
      endcase
   end
   // one answer per walk; between answers the bus shows the inverse of its last value
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         valid_out <= 1'b0;
         resp_out <= '0;
         cnt_r <= 4'h0;
         sent_r <= 1'b0;
         walks_out <= 0;
      end else begin
         valid_out <= 1'b0;
         resp_out <= ~resp_out;
         if (!req_in) begin
            cnt_r <= 4'h0;
            sent_r <= 1'b0;
         end else if (!sent_r && cnt_r == lag_in) begin
            valid_out <= 1'b1;
            resp_out <= '{fault_in, size_in, frame};
            sent_r <= 1'b1;
            walks_out <= walks_out + 1;
         end else if (!sent_r) begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule : tltb_walker

// file: test/two_level_translation_buffer_tb.sv
// two_level_translation_buffer_tb: self-checking bench of the translation buffer pair
// assumes: tltb_walker stands in for the page walker; fetch and load-store driven here
`timescale 1ns/1ps
`include "tltb_regs.svh"
module two_level_translation_buffer_tb;
   logic mclk, resetn, ce, ireq_v, dreq_v, ireq_rdy, dreq_rdy, rsp_v, wreq, wdata, wrv, wfault;
   logic [`TLTB_VA_W-1:0] ireq_va, dreq_va, wva;
   logic [1:0] wsize;
   logic [3:0] wlag;
   tltb_pkg::tltb_resp_t rsp;
   tltb_pkg::tltb_walk_t wrsp;
   int walks, err_total, compares;
   // data first-level depth under test; the evict scenario follows it
   localparam int L1D_DEPTH = `TLTB_L1D_DEF;
   // ***************************************
   // design and walker
   // ***************************************
   tltb_top #(.L1D_DEPTH(L1D_DEPTH)) tltb_top_i (.mclk_in(mclk), .resetn_in(resetn), .ce_in(ce),
      .ireq_valid_in(ireq_v), .ireq_vaddr_in(ireq_va), .ireq_ready_out(ireq_rdy),
      .dreq_valid_in(dreq_v), .dreq_vaddr_in(dreq_va), .dreq_ready_out(dreq_rdy),
      .resp_valid_out(rsp_v), .resp_out(rsp), .walk_req_out(wreq), .walk_is_data_out(wdata),
      .walk_vaddr_out(wva), .walk_resp_valid_in(wrv), .walk_resp_in(wrsp));
   tltb_walker tltb_walker_i (.clk_in(mclk), .resetn_in(resetn), .req_in(wreq),
      .vaddr_in(wva), .size_in(wsize), .fault_in(wfault), .lag_in(wlag),
      .valid_out(wrv), .resp_out(wrsp), .walks_out(walks));
   // clock at 20 MHz
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // ***************************************
   // shared tasks
   // ***************************************
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // physical address expected from the page that walked and the offset bits of va
   function automatic logic [39:0] exp_pa(input logic [47:0] va0, va, input logic [1:0] sz);
      logic [39:0] m;
      m = (sz == 2'h0) ? 40'hfff : (sz == 2'h1) ? 40'h1fffff :
          (sz == 2'h2) ? 40'h3fffffff : 40'h3fffff;
      return ({4'h9, va0[35:12], 12'h0} & ~m) | (va[39:0] & m);
   endfunction : exp_pa
   // one lookup; lat counts edges from the take to the answer
   task automatic look(input logic d, input logic [47:0] va, output int lat);
      chk({ireq_rdy, dreq_rdy}, 2'h3);
      if (d) dreq_va = va;
      else ireq_va = va;
      dreq_v = d;
      ireq_v = !d;
      @(posedge mclk);
      #1;
      ireq_v = 1'b0;
      dreq_v = 1'b0;
      lat = 1;
      while (rsp_v !== 1'b1 && lat < 200) begin
         // a miss in flight refuses new requests and shows the walk side and address
         chk({ireq_rdy, dreq_rdy}, 2'h0);
         if (wreq === 1'b1) begin
            chk({wdata, wva}, {d, va});
         end
         @(posedge mclk);
         #1;
         lat++;
      end
      // let an edge pass so the next call does not raise a valid in this same time step
      @(posedge mclk);
      #1;
   endtask : look
   // elat 0 means a walk is expected, answered four edges plus the walker's lag
   task automatic trial(input logic d, input logic [47:0] va0, va, input logic [1:0] sz,
         input int elat);
      int lat;
      int w0;
      w0 = walks;
      wsize = sz;
      look(d, va, lat);
      chk(lat, (elat == 0) ? 4 + wlag : elat);
      chk(walks - w0, elat == 0);
      chk({rsp.data, rsp.fault, rsp.paddr}, {d, 1'b0, exp_pa(va0, va, sz)});
   endtask : trial
   // ***************************************
   // scenarios
   // ***************************************
   // every page size on both sides; a second address in the page hits without a walk
   task automatic t_sizes();
      logic [47:0] va0, off;
      wlag = 4'h5;
      for (int d = 0; d < 2; d++) begin
         for (int s = 0; s < 4; s++) begin
            va0 = {13'h0, d[0], s[1:0], 32'h4567_8000};
            off = (s == 0) ? 48'ha8 : (s == 1) ? 48'h1f_f000 :
                  (s == 2) ? 48'h3ff0_0000 : 48'h20_0000;
            trial(d[0], va0, va0, s[1:0], 0);
            trial(d[0], va0, va0 ^ off, s[1:0], 1);
         end
      end
   endtask : t_sizes
   // overflow the first level by one page; the victim then comes from the second level
   task automatic t_evict(input logic d, input int n, input logic [47:0] base, step);
      wlag = 4'h0;
      for (int i = 0; i < n; i++) begin
         trial(d, base + i * step, base + i * step, 2'h0, 0);
      end
      trial(d, base, base + 48'h10, 2'h0, 2);
      trial(d, base, base + 48'h20, 2'h0, 1);
   endtask : t_evict
   // a faulting walk answers with fault and no address, and fills nothing
   task automatic t_fault();
      int lat;
      wfault = 1'b1;
      look(1'b1, 48'h7000_0000_3000, lat);
      chk({rsp.fault, rsp.paddr}, {1'b1, 40'h0});
      wfault = 1'b0;
      trial(1'b1, 48'h7000_0000_3000, 48'h7000_0000_3000, 2'h0, 0);
   endtask : t_fault
   task automatic conclude();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude
   // ***************************************
   // main sequence and watchdog
   // ***************************************
   initial begin
      err_total = 0;
      compares = 0;
      resetn = 1'b0;
      ce = 1'b1;
      ireq_v = 1'b0;
      dreq_v = 1'b0;
      ireq_va = '0;
      dreq_va = '0;
      wsize = 2'h0;
      wfault = 1'b0;
      wlag = 4'h0;
      repeat (3) @(posedge mclk);
      #1 resetn = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      t_sizes();
      t_evict(1'b0, `TLTB_L1I_SMALL + 1, 48'h5000_0000_0000, 48'h1000);
      t_evict(1'b1, L1D_DEPTH + 1, 48'h6000_0000_0000, 48'h4000_0000);
      t_fault();
      conclude();
   end
   // the full run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      conclude();
   end
endmodule : two_level_translation_buffer_tb
